/* logic/wwd_consts.svh */
/*
  Offsets, field positions, keys and timing constants of the windowed
  watchdog. Assumes a 32-bit AHB-Lite bus and a 1 kHz counter clock.
*/
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH

// Register byte offsets, decoded on the low address byte.
`define WWD_OFF_CONTROL_REGISTER_A 8'h00
`define WWD_OFF_STATUS 8'h04
`define WWD_OFF_CCP 8'h08
`define WWD_OFF_REFRESH 8'h0c
`define WWD_ADDR_MSB 7

// Field layout of control register A and the status register.
`define WWD_PERIOD_MSB 3
`define WWD_PERIOD_LSB 0
`define WWD_WINDOW_MSB 7
`define WWD_WINDOW_LSB 4
`define WWD_LOCK_BIT 7
`define WWD_BUSY_BIT 0
`define WWD_CTRL_MSB 7

// Unlock key and the number of transfers the unlock stays open.
`define WWD_CCP_KEY 8'h5a
`define WWD_CCP_XFERS 3'h4

// Counter clock ticks a write or a refresh takes to cross over.
`define WWD_SYNC_TICKS 2'h2

// Timeout codes: 1 is the shortest, 11 the longest.
`define WWD_CODE_OFF 4'h0
`define WWD_CODE_MIN 4'h1
`define WWD_CODE_MAX 4'hb
`define WWD_MIN_TIMEOUT_MS 8
`define WWD_TICK_HZ 1000
`define WWD_MIN_TICKS (`WWD_MIN_TIMEOUT_MS * `WWD_TICK_HZ / 1000)
`define WWD_CNT_W 14

// Bus encodings.
`define WWD_HTRANS_ACT_BIT 1
`define WWD_RDATA_W 32

`endif

/* logic/wwd_pkg.sv */
/*
  Types of the windowed watchdog: states, register selects and the
  packed state records of each module. Assumes wwd_consts.svh.
*/
`include "wwd_consts.svh"

package wwd_pkg;

  typedef enum logic [2:0] {
    WWD_OFF,
    WWD_NORMAL,
    WWD_FIRST,
    WWD_CLOSED,
    WWD_OPEN
  } wwd_state_t;

  typedef enum logic [2:0] {
    WWD_SEL_CTRL,
    WWD_SEL_STATUS,
    WWD_SEL_CCP,
    WWD_SEL_REFRESH,
    WWD_SEL_NONE
  } wwd_sel_t;

  typedef struct packed {
    logic valid;
    logic write;
    wwd_sel_t sel;
  } wwd_ap_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } wwd_sync_t;

  typedef struct packed {
    logic open;
    logic [2:0] cnt;
  } wwd_ccp_t;

  typedef struct packed {
    logic boot;
    logic hready;
    logic [`WWD_RDATA_W-1:0] hrdata;
    wwd_ap_t ap;
    logic req;
    logic lvl_prev;
    logic [`WWD_CTRL_MSB:0] ctrl_sh;
    logic [`WWD_CTRL_MSB:0] ctrl_act;
    logic lock;
    logic sync_busy;
    logic [1:0] sync_cnt;
    logic ref_pend;
    logic [1:0] ref_cnt;
    wwd_state_t state;
    logic [`WWD_CNT_W-1:0] cnt;
  } wwd_regs_t;

endpackage

/* logic/wwd_sync3.sv */
/*
  Three-flop synchroniser for one level from outside the MCLK domain.
  The output follows only once the second and third flops agree.
*/
`timescale 1ns/1ps
`include "wwd_consts.svh"

module wwd_sync3 (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic din,
  output logic dout
);

  wwd_pkg::wwd_sync_t s;
  wwd_pkg::wwd_sync_t s_n;

  always_comb
  begin
    s_n = s;
    s_n.s1 = din;
    s_n.s2 = s.s1;
    s_n.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      s_n.lvl = s.s3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else if (ce)
    begin
      s <= s_n;
    end
  end

  assign dout = s.lvl;

endmodule

/* logic/wwd_ccp.sv */
/*
  Timed unlock for protected writes. A key write opens it; it closes
  after a protected write or a fixed number of further bus transfers.
*/
`timescale 1ns/1ps
`include "wwd_consts.svh"

module wwd_ccp (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic key_hit,
  input logic xfer,
  input logic used,
  output logic open_o
);

  wwd_pkg::wwd_ccp_t s;
  wwd_pkg::wwd_ccp_t s_n;

  always_comb
  begin
    s_n = s;
    if (key_hit)
    begin
      s_n.open = 1'b1;
      s_n.cnt = '0;
    end
    else if (s.open && (used || (xfer && s.cnt == `WWD_CCP_XFERS - 3'h1)))
    begin
      s_n.open = 1'b0;
    end
    else if (s.open && xfer)
    begin
      s_n.cnt = s.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else if (ce)
    begin
      s <= s_n;
    end
  end

  assign open_o = s.open;

endmodule

/* logic/wwd_top.sv */
/*
  Windowed watchdog with an AHB-Lite register slave. The counter
  advances on ticks of an outside 1 kHz clock sampled in MCLK.
  Assumes a reset controller that answers RESET_REQ with RESET_ACK.
*/
`timescale 1ns/1ps
`include "wwd_consts.svh"

module wwd_top (
  input logic MCLK,
  input logic RST,
  input logic CE,
  input logic HSEL,
  input logic [31:0] HADDR,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic [2:0] HSIZE,
  input logic [31:0] HWDATA,
  input logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input logic WDT_CLK,
  input logic DEBUG_HALT,
  input logic DEBUG_MODE,
  input logic [7:0] BOOT_FUSE,
  input logic RESET_ACK,
  output logic RESET_REQ
);

  localparam wwd_pkg::wwd_regs_t RST_VAL = '{
    boot: 1'b1,
    hready: 1'b1,
    state: wwd_pkg::WWD_OFF,
    default: '0
  };

  wwd_pkg::wwd_regs_t s;
  wwd_pkg::wwd_regs_t s_n;
  logic wdt_lvl;
  logic ccp_open;
  logic tick;
  logic key_hit;
  logic ccp_used;
  logic wr_ctrl;
  logic wr_stat;
  logic ctrl_wr_ok;
  logic ref_issue;
  logic ctrl_apply;
  logic refresh_apply;
  logic fire;
  logic [`WWD_CNT_W-1:0] limit_m1;

  function automatic logic [`WWD_CNT_W-1:0] ticks_of(
    input logic [3:0] code
  );
    logic [3:0] c;
    c = (code > `WWD_CODE_MAX) ? `WWD_CODE_MAX : code;
    if (c == `WWD_CODE_OFF)
    begin
      c = `WWD_CODE_MIN;
    end
    ticks_of = `WWD_CNT_W'(`WWD_MIN_TICKS) << (c - `WWD_CODE_MIN);
  endfunction

  function automatic logic [3:0] period_of(input logic [7:0] ctrl);
    period_of = ctrl[`WWD_PERIOD_MSB:`WWD_PERIOD_LSB];
  endfunction

  function automatic logic [3:0] window_of(input logic [7:0] ctrl);
    window_of = ctrl[`WWD_WINDOW_MSB:`WWD_WINDOW_LSB];
  endfunction

  // enable by period, window select, wait first refresh
  function automatic wwd_pkg::wwd_state_t mode_of(input logic [7:0] ctrl);
    if (period_of(ctrl) == `WWD_CODE_OFF)
    begin
      mode_of = wwd_pkg::WWD_OFF;
    end
    else if (window_of(ctrl) != `WWD_CODE_OFF)
    begin
      mode_of = wwd_pkg::WWD_FIRST;
    end
    else
    begin
      mode_of = wwd_pkg::WWD_NORMAL;
    end
  endfunction

  function automatic wwd_pkg::wwd_sel_t decode(input logic [7:0] a);
    if (a == `WWD_OFF_CONTROL_REGISTER_A)
    begin
      decode = wwd_pkg::WWD_SEL_CTRL;
    end
    else if (a == `WWD_OFF_STATUS)
    begin
      decode = wwd_pkg::WWD_SEL_STATUS;
    end
    else if (a == `WWD_OFF_CCP)
    begin
      decode = wwd_pkg::WWD_SEL_CCP;
    end
    else if (a == `WWD_OFF_REFRESH)
    begin
      decode = wwd_pkg::WWD_SEL_REFRESH;
    end
    else
    begin
      decode = wwd_pkg::WWD_SEL_NONE;
    end
  endfunction

  wwd_sync3 u_sync (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .din(WDT_CLK),
    .dout(wdt_lvl)
  );

  wwd_ccp u_ccp (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .key_hit(key_hit),
    .xfer(s.ap.valid),
    .used(ccp_used),
    .open_o(ccp_open)
  );

  always_comb
  begin
    wwd_pkg::wwd_sel_t sel;
    sel = decode(HADDR[`WWD_ADDR_MSB:0]);
    s_n = s;
    s_n.hready = 1'b1;
    s_n.hrdata = '0;
    s_n.lvl_prev = wdt_lvl;
    tick = wdt_lvl & ~s.lvl_prev;
    ctrl_apply = 1'b0;
    refresh_apply = 1'b0;
    fire = 1'b0;
    limit_m1 = ticks_of((s.state == wwd_pkg::WWD_CLOSED) ?
      window_of(s.ctrl_act) : period_of(s.ctrl_act)) - `WWD_CNT_W'(1);

    // Address phase: read data is registered for the data phase.
    s_n.ap.valid = HSEL && HTRANS[`WWD_HTRANS_ACT_BIT] && HREADY;
    s_n.ap.write = HWRITE;
    s_n.ap.sel = sel;
    if (s_n.ap.valid && !HWRITE)
    begin
      if (sel == wwd_pkg::WWD_SEL_CTRL)
      begin
        s_n.hrdata[`WWD_CTRL_MSB:0] = s.ctrl_sh;
      end
      else if (sel == wwd_pkg::WWD_SEL_STATUS)
      begin
        s_n.hrdata[`WWD_LOCK_BIT] = s.lock;
        s_n.hrdata[`WWD_BUSY_BIT] = s.sync_busy;
      end
    end

    // Data phase writes.
    wr_ctrl = s.ap.valid && s.ap.write && s.ap.sel == wwd_pkg::WWD_SEL_CTRL;
    wr_stat = s.ap.valid && s.ap.write &&
      s.ap.sel == wwd_pkg::WWD_SEL_STATUS;
    key_hit = s.ap.valid && s.ap.write &&
      s.ap.sel == wwd_pkg::WWD_SEL_CCP &&
      HWDATA[`WWD_CTRL_MSB:0] == `WWD_CCP_KEY;
    // guarded control write, refused while busy
    ctrl_wr_ok = wr_ctrl && ccp_open && !s.lock && !s.sync_busy;
    ccp_used = ctrl_wr_ok || (wr_stat && ccp_open);
    ref_issue = s.ap.valid && s.ap.write &&
      s.ap.sel == wwd_pkg::WWD_SEL_REFRESH && !s.ref_pend &&
      !DEBUG_HALT && period_of(s.ctrl_act) != `WWD_CODE_OFF;
    if (ctrl_wr_ok)
    begin
      s_n.ctrl_sh = HWDATA[`WWD_CTRL_MSB:0];
      s_n.sync_busy = 1'b1;
      s_n.sync_cnt = '0;
    end
    if (wr_stat && ccp_open)
    begin
      if (HWDATA[`WWD_LOCK_BIT])
      begin
        s_n.lock = 1'b1;
      end
      else if (DEBUG_MODE)
      begin
        s_n.lock = 1'b0;
      end
    end
    if (ref_issue)
    begin
      s_n.ref_pend = 1'b1;
      s_n.ref_cnt = '0;
    end

    // control write applied after sync ticks
    if (tick && s.sync_busy)
    begin
      if (s.sync_cnt == `WWD_SYNC_TICKS - 2'h1)
      begin
        ctrl_apply = 1'b1;
        s_n.ctrl_act = s.ctrl_sh;
        s_n.sync_busy = 1'b0;
      end
      else
      begin
        s_n.sync_cnt = s.sync_cnt + 2'h1;
      end
    end
    if (tick && s.ref_pend)
    begin
      if (s.ref_cnt == `WWD_SYNC_TICKS - 2'h1)
      begin
        refresh_apply = 1'b1;
        s_n.ref_pend = 1'b0;
      end
      else
      begin
        s_n.ref_cnt = s.ref_cnt + 2'h1;
      end
    end

    if (DEBUG_HALT)
    begin
      s_n.cnt = '0;
      s_n.ref_pend = 1'b0;
      s_n.state = mode_of(s_n.ctrl_act);
    end
    else if (ctrl_apply)
    begin
      s_n.cnt = '0;
      s_n.state = mode_of(s.ctrl_sh);
    end
    else if (tick && s.state != wwd_pkg::WWD_OFF)
    begin
      if (refresh_apply)
      begin
        s_n.cnt = '0;
        case (s.state)
          wwd_pkg::WWD_NORMAL: s_n.state = wwd_pkg::WWD_NORMAL;
          wwd_pkg::WWD_FIRST: s_n.state = wwd_pkg::WWD_CLOSED;
          wwd_pkg::WWD_OPEN: s_n.state = wwd_pkg::WWD_CLOSED;
          default: fire = 1'b1;
        endcase
      end
      else if (s.cnt == limit_m1)
      begin
        s_n.cnt = '0;
        if (s.state == wwd_pkg::WWD_CLOSED)
        begin
          s_n.state = wwd_pkg::WWD_OPEN;
        end
        else
        begin
          fire = 1'b1;
        end
      end
      else
      begin
        s_n.cnt = s.cnt + `WWD_CNT_W'(1);
      end
    end

    s_n.req = (s.req & ~RESET_ACK) | fire;

    if (s.boot)
    begin
      s_n.boot = 1'b0;
      s_n.ctrl_sh = BOOT_FUSE;
      s_n.ctrl_act = BOOT_FUSE;
      s_n.lock = period_of(BOOT_FUSE) != `WWD_CODE_OFF;
      s_n.state = mode_of(BOOT_FUSE);
      s_n.cnt = '0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      s <= RST_VAL;
    end
    else if (CE)
    begin
      s <= s_n;
    end
  end

  assign HRDATA = s.hrdata;
  assign HREADYOUT = s.hready;
  assign HRESP = 1'b0;
  assign RESET_REQ = s.req;

  property p_req_hold;
    @(posedge MCLK) disable iff (RST)
    RESET_REQ && !RESET_ACK |=> RESET_REQ;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("reset request dropped without ack");

  property p_timeout;
    @(posedge MCLK) disable iff (RST)
    CE && !s.boot && tick && !DEBUG_HALT && !ctrl_apply && !refresh_apply &&
    s.state == wwd_pkg::WWD_NORMAL && s.cnt == limit_m1 |=> RESET_REQ;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not request reset");

  property p_early;
    @(posedge MCLK) disable iff (RST)
    CE && !s.boot && !DEBUG_HALT && !ctrl_apply && refresh_apply &&
    s.state == wwd_pkg::WWD_CLOSED |=> RESET_REQ;
  endproperty
  a_early: assert property (p_early)
    else $error("early refresh did not request reset");

  property p_restart;
    @(posedge MCLK) disable iff (RST)
    CE && !s.boot && !DEBUG_HALT && !ctrl_apply && refresh_apply &&
    s.state == wwd_pkg::WWD_NORMAL
    |=> s.cnt == '0 && s.state == wwd_pkg::WWD_NORMAL;
  endproperty
  a_restart: assert property (p_restart)
    else $error("refresh did not restart counter");

  property p_halt;
    @(posedge MCLK) disable iff (RST)
    CE && DEBUG_HALT |=> s.cnt == '0 && !s.ref_pend;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not clear counter");

  property p_resume;
    @(posedge MCLK) disable iff (RST)
    CE && DEBUG_HALT && !s.boot && !s.sync_busy &&
    period_of(s.ctrl_act) != `WWD_CODE_OFF &&
    window_of(s.ctrl_act) != `WWD_CODE_OFF
    |=> s.state == wwd_pkg::WWD_FIRST;
  endproperty
  a_resume: assert property (p_resume)
    else $error("halt did not rearm first window");

  property p_lock;
    @(posedge MCLK) disable iff (RST)
    CE && !s.boot && s.lock && wr_ctrl |=> $stable(s.ctrl_sh);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked control changed");

  property p_ccp;
    @(posedge MCLK) disable iff (RST)
    CE && !s.boot && wr_ctrl && !ccp_open |=> $stable(s.ctrl_sh);
  endproperty
  a_ccp: assert property (p_ccp)
    else $error("control changed without unlock");

  property p_busy;
    @(posedge MCLK) disable iff (RST)
    CE && !s.boot && ctrl_wr_ok |=> s.sync_busy && s.ctrl_act == $past(s.ctrl_act);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not raised on control write");

  property p_boot;
    @(posedge MCLK) disable iff (RST)
    CE && s.boot && period_of(BOOT_FUSE) != `WWD_CODE_OFF |=> s.lock;
  endproperty
  a_boot: assert property (p_boot)
    else $error("fuse enable did not set lock");

  property p_off;
    @(posedge MCLK) disable iff (RST)
    CE && !s.boot && ctrl_apply && period_of(s.ctrl_sh) == `WWD_CODE_OFF
    |=> s.state == wwd_pkg::WWD_OFF;
  endproperty
  a_off: assert property (p_off)
    else $error("zero period left watchdog running");

  c_fire: cover property (@(posedge MCLK) disable iff (RST) fire);
  c_open: cover property (@(posedge MCLK) disable iff (RST)
    s.state == wwd_pkg::WWD_OPEN);
  c_apply: cover property (@(posedge MCLK) disable iff (RST) ctrl_apply);
  c_halt: cover property (@(posedge MCLK) disable iff (RST)
    DEBUG_HALT && s.state == wwd_pkg::WWD_FIRST);

endmodule

/* dv/wwd_cpu.sv */
/*
  Bus master standing in for the processor core: single-word AHB-Lite
  transfers and the timed unlock. Assumes one slave driving hready.
*/
`timescale 1ns/1ps
`include "wwd_consts.svh"

module wwd_cpu (
  input logic clk,
  input logic hready,
  input logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Write data is inverted in the address phase so stale data is wrong.
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    rd = hrdata;
  endtask

  task automatic prot(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, `WWD_OFF_CCP, {24'h0, `WWD_CCP_KEY}, x);
    xfer(1'b1, a, d, x);
  endtask
endmodule

/* dv/testbench.sv */
/*
  Self-checking bench: unlock, timeouts, window slots, debug halt, lock
  and fuse boot. Assumes wwd_top and the wwd_cpu bus master.
*/
`timescale 1ns/1ps
`include "wwd_consts.svh"

module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wclk = 1'b0;
  logic dbg = 1'b0;
  logic dmode = 1'b0;
  logic [7:0] fuse = 8'h0;
  logic ackq = 1'b0;
  logic ce = 1'b1;
  logic hsel, hwrite, hready, hresp, req;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int errors = 0;
  int n_tests = 0;
  int ticks = 0;
  int mark = 0;
  int cyc = 0;

  always #2 mclk = ~mclk;
  always #50.3 wclk = ~wclk;
  always @(posedge wclk) ticks++;

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      final_report();
    end
  end

  wwd_top dut (.MCLK(mclk), .RST(rst), .CE(ce), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .WDT_CLK(wclk),
    .DEBUG_HALT(dbg), .DEBUG_MODE(dmode), .BOOT_FUSE(fuse),
    .RESET_ACK(ackq), .RESET_REQ(req));

  wwd_cpu cpu (.clk(mclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  task final_report;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input string s);
    cpu.xfer(1'b0, a, 32'h0, r);
    chk(s, e, r);
  endtask

  task automatic tk(input int n);
    int t0;
    t0 = ticks;
    while (ticks - t0 < n)
      @(posedge mclk);
  endtask

  // Counts counter ticks from mark until the reset request shows.
  task automatic wreq(input int lo, input int hi, input string s);
    while (req !== 1'b1 && ticks - mark <= hi)
      @(posedge mclk);
    n_tests++;
    if (req !== 1'b1 || ticks - mark < lo)
    begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", s, lo, hi,
        ticks - mark);
    end
  endtask

  task ack;
    repeat (10) @(posedge mclk);
    chk("req held", 32'h1, {31'h0, req});
    ackq <= 1'b1;
    @(posedge mclk);
    ackq <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("req cleared", 32'h0, {31'h0, req});
  endtask

  task idle;
    r = 32'h1;
    repeat (200)
      if (r[0] !== 1'b0)
        cpu.xfer(1'b0, `WWD_OFF_STATUS, 32'h0, r);
    chk("busy cleared", 32'h0, {31'h0, r[0]});
  endtask

  task automatic setc(input logic [7:0] d);
    cpu.prot(`WWD_OFF_CONTROL_REGISTER_A, {24'h0, d});
    cpu.xfer(1'b0, `WWD_OFF_STATUS, 32'h0, r);
    chk("busy set", 32'h1, {31'h0, r[0]});
    idle();
    rd(`WWD_OFF_CONTROL_REGISTER_A, {24'h0, d}, "ctrl");
  endtask

  task automatic do_reset(input logic [7:0] f);
    fuse <= f;
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  task watchdog_refresh_instruction;
    cpu.xfer(1'b1, `WWD_OFF_REFRESH, 32'h0, r);
  endtask

  initial
  begin
    do_reset(8'h00);
    rd(`WWD_OFF_CONTROL_REGISTER_A, 32'h0, "ctrl reset");
    rd(`WWD_OFF_STATUS, 32'h0, "status reset");
    rd(8'h10, 32'h0, "unmapped");
    chk("hresp", 32'h0, {31'h0, hresp});
    cpu.xfer(1'b1, `WWD_OFF_CONTROL_REGISTER_A, 32'h1, r);
    rd(`WWD_OFF_CONTROL_REGISTER_A, 32'h0, "no unlock");
    tk(20);
    chk("disabled", 32'h0, {31'h0, req});
    $display("test reset done");
    for (int n = 1; n <= 3; n++)
    begin
      mark = ticks;
      setc(8'(n));
      wreq((8 << (n - 1)) + 1, (8 << (n - 1)) + 4, "timeout");
      ack();
    end
    setc(8'h01);
    repeat (4)
    begin
      watchdog_refresh_instruction();
      tk(5);
    end
    chk("refreshed", 32'h0, {31'h0, req});
    mark = ticks;
    watchdog_refresh_instruction();
    wreq(9, 12, "after refresh");
    ack();
    $display("test normal done");
    setc(8'h12);
    tk(3);
    watchdog_refresh_instruction();
    tk(4);
    chk("first refresh", 32'h0, {31'h0, req});
    mark = ticks;
    watchdog_refresh_instruction();
    wreq(1, 4, "early refresh");
    ack();
    tk(12);
    mark = ticks;
    watchdog_refresh_instruction();
    tk(4);
    chk("open refresh", 32'h0, {31'h0, req});
    wreq(25, 29, "closed plus open");
    ack();
    $display("test window done");
    dbg <= 1'b1;
    watchdog_refresh_instruction();
    tk(40);
    chk("halted", 32'h0, {31'h0, req});
    mark = ticks;
    dbg <= 1'b0;
    wreq(15, 18, "normal after halt");
    ack();
    ce <= 1'b0;
    tk(40);
    chk("frozen", 32'h0, {31'h0, req});
    ce <= 1'b1;
    $display("test debug done");
    cpu.prot(`WWD_OFF_STATUS, 32'h80);
    rd(`WWD_OFF_STATUS, 32'h80, "lock set");
    cpu.prot(`WWD_OFF_CONTROL_REGISTER_A, 32'h0);
    rd(`WWD_OFF_CONTROL_REGISTER_A, 32'h12, "locked ctrl");
    cpu.prot(`WWD_OFF_STATUS, 32'h0);
    rd(`WWD_OFF_STATUS, 32'h80, "lock kept");
    dmode <= 1'b1;
    cpu.prot(`WWD_OFF_STATUS, 32'h0);
    dmode <= 1'b0;
    rd(`WWD_OFF_STATUS, 32'h0, "lock cleared");
    for (int m = 4; m >= 3; m--)
    begin
      cpu.xfer(1'b1, `WWD_OFF_CCP, {24'h0, `WWD_CCP_KEY}, r);
      repeat (m) cpu.xfer(1'b0, 8'h10, 32'h0, r);
      cpu.xfer(1'b1, `WWD_OFF_CONTROL_REGISTER_A, 32'h1, r);
      idle();
      rd(`WWD_OFF_CONTROL_REGISTER_A, m == 4 ? 32'h12 : 32'h1, "span");
    end
    setc(8'h00);
    tk(20);
    chk("disabled again", 32'h0, {31'h0, req});
    $display("test lock done");
    do_reset(8'h13);
    rd(`WWD_OFF_CONTROL_REGISTER_A, 32'h13, "fuse ctrl");
    rd(`WWD_OFF_STATUS, 32'h80, "fuse lock");
    $display("test fuse done");
    final_report();
  end
endmodule
